// ==== hw/txsb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "txsb_consts.svh"

module txsb_top #(
   parameter int unsigned HPD_QUAL_CYCLES = `TXSB_HPD_QUAL_CYC,
   parameter bit INCLUDE_DDC = 1'b1
) (
   // Clock, reset, enable
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clk_en,
   // Oversampling
   input wire logic [1:0] oversample_select,
   output logic [2:0] oversample_factor,
   // Hot-plug
   input wire logic hpd_in,
   output logic hpd_valid,
   // DDC lines, open drain
   input wire logic ddc_scl_in,
   output logic ddc_scl_out,
   output logic ddc_scl_oe,
   input wire logic ddc_sda_in,
   output logic ddc_sda_out,
   output logic ddc_sda_oe,
   // Management port
   input wire logic [3:0] mgmt_address,
   input wire logic mgmt_write,
   input wire logic mgmt_read,
   input wire logic [31:0] mgmt_writedata,
   output logic [31:0] mgmt_readdata
);

   localparam logic [`TXSB_HPD_CNT_W-1:0] HPD_MAX = `TXSB_HPD_CNT_W'(HPD_QUAL_CYCLES);
   localparam logic [`TXSB_DDC_QCNT_W-1:0] QTR_LAST = `TXSB_DDC_QCNT_W'(`TXSB_DDC_QTR_CYC - 1);

   // Pin synchronisers: 0 = hot-plug, 1 = scl, 2 = sda
   logic [2:0] pin_raw;
   logic [2:0] sync1_q, sync2_q, sync3_q, lvl_q;
   logic [2:0] sync1_d, sync2_d, sync3_d, lvl_d;

   assign pin_raw = {ddc_sda_in, ddc_scl_in, hpd_in};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sync
         always_comb begin
            sync1_d[gi] = pin_raw[gi];
            sync2_d[gi] = sync1_q[gi];
            sync3_d[gi] = sync2_q[gi];
            // A change only counts once the second and third stages agree
            lvl_d[gi] = (sync2_q[gi] == sync3_q[gi]) ? sync2_q[gi] : lvl_q[gi];
         end
      end
   endgenerate

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
         sync3_q <= 3'h0;
         lvl_q <= 3'h0;
      end else if (clk_en) begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         sync3_q <= sync3_d;
         lvl_q <= lvl_d;
      end
   end

   // Hot-plug qualification and oversampling decode
   logic [`TXSB_HPD_CNT_W-1:0] hpd_cnt_q, hpd_cnt_d;
   logic hpd_valid_q, hpd_valid_d;
   logic [2:0] os_factor_q, os_factor_d;

   always_comb begin
      if (!lvl_q[0]) begin
         hpd_cnt_d = '0;
         hpd_valid_d = 1'b0;
      end else begin
         hpd_cnt_d = (hpd_cnt_q == HPD_MAX) ? hpd_cnt_q : hpd_cnt_q + 1'b1;
         hpd_valid_d = (hpd_cnt_q == HPD_MAX);
      end
      unique case (oversample_select)
         2'h0: os_factor_d = `TXSB_OS_FACTOR0;
         2'h1: os_factor_d = `TXSB_OS_FACTOR1;
         2'h2: os_factor_d = `TXSB_OS_FACTOR2;
         2'h3: os_factor_d = `TXSB_OS_FACTOR3;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         hpd_cnt_q <= '0;
         hpd_valid_q <= 1'b0;
         os_factor_q <= `TXSB_OS_FACTOR0;
      end else if (clk_en) begin
         hpd_cnt_q <= hpd_cnt_d;
         hpd_valid_q <= hpd_valid_d;
         os_factor_q <= os_factor_d;
      end
   end

   assign hpd_valid = hpd_valid_q;
   assign oversample_factor = os_factor_q;

   // DDC byte engine behind the management port
   txsb_pkg::txsb_ddc_state_type st_q, st_d;
   logic [1:0] ph_q, ph_d;
   logic [`TXSB_DDC_QCNT_W-1:0] qcnt_q, qcnt_d;
   logic [3:0] bitn_q, bitn_d;
   logic [8:0] tx_q, tx_d, rx_q, rx_d;
   logic stop_q, stop_d;
   logic scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
   logic [31:0] rdata_q, rdata_d;
   logic tick, advance, cmd_take;

   always_comb begin
      st_d = st_q;
      ph_d = ph_q;
      qcnt_d = qcnt_q;
      bitn_d = bitn_q;
      tx_d = tx_q;
      rx_d = rx_q;
      stop_d = stop_q;
      scl_oe_d = scl_oe_q;
      sda_oe_d = sda_oe_q;
      tick = (qcnt_q == QTR_LAST);
      // Quarter 2 follows the clock release; it waits for the line to read high, so a stretching sink holds the bit
      advance = tick && !(ph_q == 2'h2 && !lvl_q[1]);
      // Commands arriving while busy are dropped; software polls the busy bit first
      cmd_take = INCLUDE_DDC && mgmt_write && (mgmt_address == `TXSB_ADDR_CMD)
                 && (st_q == txsb_pkg::DDC_IDLE);
      if (st_q != txsb_pkg::DDC_IDLE) begin
         qcnt_d = tick ? '0 : qcnt_q + 1'b1;
         if (tick && !advance) begin
            qcnt_d = qcnt_q;
         end
      end
      if (cmd_take) begin
         st_d = mgmt_writedata[`TXSB_CMD_START] ? txsb_pkg::DDC_START : txsb_pkg::DDC_BITS;
         ph_d = 2'h0;
         qcnt_d = '0;
         bitn_d = 4'h0;
         stop_d = mgmt_writedata[`TXSB_CMD_STOP];
         tx_d = mgmt_writedata[`TXSB_CMD_READ] ? {8'hFF, mgmt_writedata[`TXSB_CMD_NACK]}
                                               : {mgmt_writedata[`TXSB_CMD_DATA_MSB:0], 1'b1};
      end else if (advance) begin
         ph_d = ph_q + 2'h1;
         unique case (st_q)
            txsb_pkg::DDC_IDLE: begin
               ph_d = 2'h0;
            end
            txsb_pkg::DDC_START: begin
               unique case (ph_q)
                  2'h0: begin
                     sda_oe_d = 1'b0;
                     scl_oe_d = 1'b0;
                  end
                  2'h1: sda_oe_d = 1'b0;
                  2'h2: sda_oe_d = 1'b1;
                  2'h3: begin
                     scl_oe_d = 1'b1;
                     st_d = txsb_pkg::DDC_BITS;
                  end
               endcase
            end
            txsb_pkg::DDC_BITS: begin
               unique case (ph_q)
                  2'h0: begin
                     scl_oe_d = 1'b1;
                     sda_oe_d = ~tx_q[8];
                  end
                  2'h1: scl_oe_d = 1'b0;
                  2'h2: rx_d = {rx_q[7:0], lvl_q[2]};
                  2'h3: begin
                     scl_oe_d = 1'b1;
                     tx_d = {tx_q[7:0], 1'b1};
                     bitn_d = bitn_q + 4'h1;
                     if (bitn_q == 4'h8) begin
                        st_d = stop_q ? txsb_pkg::DDC_STOP : txsb_pkg::DDC_IDLE;
                     end
                  end
               endcase
            end
            txsb_pkg::DDC_STOP: begin
               unique case (ph_q)
                  2'h0: begin
                     scl_oe_d = 1'b1;
                     sda_oe_d = 1'b1;
                  end
                  2'h1: scl_oe_d = 1'b0;
                  2'h2: sda_oe_d = 1'b0;
                  2'h3: st_d = txsb_pkg::DDC_IDLE;
               endcase
            end
         endcase
      end
      // Read answers one cycle after the strobe
      rdata_d = 32'h0;
      if (INCLUDE_DDC && mgmt_read && mgmt_address == `TXSB_ADDR_STAT) begin
         rdata_d[`TXSB_STAT_BUSY] = (st_q != txsb_pkg::DDC_IDLE);
         rdata_d[`TXSB_STAT_NACK] = rx_q[0];
         rdata_d[`TXSB_STAT_RX_MSB:`TXSB_STAT_RX_LSB] = rx_q[8:1];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_q <= txsb_pkg::DDC_IDLE;
         ph_q <= 2'h0;
         qcnt_q <= '0;
         bitn_q <= 4'h0;
         tx_q <= 9'h1FF;
         rx_q <= 9'h000;
         stop_q <= 1'b0;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
         rdata_q <= 32'h0;
      end else if (clk_en) begin
         st_q <= st_d;
         ph_q <= ph_d;
         qcnt_q <= qcnt_d;
         bitn_q <= bitn_d;
         tx_q <= tx_d;
         rx_q <= rx_d;
         stop_q <= stop_d;
         scl_oe_q <= scl_oe_d;
         sda_oe_q <= sda_oe_d;
         rdata_q <= rdata_d;
      end
   end

   // Open drain: the lines are only ever pulled low, never driven high
   assign ddc_scl_out = 1'b0;
   assign ddc_sda_out = 1'b0;
   assign ddc_scl_oe = scl_oe_q;
   assign ddc_sda_oe = sda_oe_q;
   assign mgmt_readdata = rdata_q;

endmodule

`default_nettype wire

// ==== hw/txsb_consts.svh ====
`ifndef TXSB_CONSTS_SVH
`define TXSB_CONSTS_SVH

// Reference clock
`define TXSB_CLK_HZ 20000000
`define TXSB_CLK_NS 50

// Hot-plug qualification time and its cycle count ("longer than" adds one cycle)
`define TXSB_HPD_QUAL_MS 100
`define TXSB_HPD_QUAL_CYC ((`TXSB_HPD_QUAL_MS * (`TXSB_CLK_HZ / 1000)) + 1)
`define TXSB_HPD_CNT_W 22

// DDC quarter bit time at 100 kHz, rounded up to whole cycles
`define TXSB_DDC_QTR_NS 2500
`define TXSB_DDC_QTR_CYC ((`TXSB_DDC_QTR_NS + `TXSB_CLK_NS - 1) / `TXSB_CLK_NS)
`define TXSB_DDC_QCNT_W 8

// Management port word addresses
`define TXSB_ADDR_CMD 4'h0
`define TXSB_ADDR_STAT 4'h1

// Command word fields
`define TXSB_CMD_DATA_MSB 7
`define TXSB_CMD_START 8
`define TXSB_CMD_STOP 9
`define TXSB_CMD_READ 10
`define TXSB_CMD_NACK 11

// Status word fields
`define TXSB_STAT_BUSY 0
`define TXSB_STAT_NACK 1
`define TXSB_STAT_RX_LSB 8
`define TXSB_STAT_RX_MSB 15

// Oversampling factors for select codes 0..3
`define TXSB_OS_FACTOR0 3'h1
`define TXSB_OS_FACTOR1 3'h3
`define TXSB_OS_FACTOR2 3'h4
`define TXSB_OS_FACTOR3 3'h5

`endif

// ==== hw/txsb_pkg.sv ====
package txsb_pkg;

   typedef enum logic [1:0] {
      DDC_IDLE = 2'h0,
      DDC_START = 2'h1,
      DDC_BITS = 2'h3,
      DDC_STOP = 2'h2
   } txsb_ddc_state_type;

endpackage

// ==== sim/txsb_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module txsb_props #(
   parameter int unsigned HPD_QUAL_CYCLES = 20
) (
   // Clock and control
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic [1:0] oversample_select,
   input wire logic [2:0] oversample_factor,
   // Hot-plug
   input wire logic hpd_in,
   input wire logic hpd_valid,
   // DDC and port
   input wire logic ddc_scl_out,
   input wire logic ddc_sda_out,
   input wire logic ddc_scl_oe,
   input wire logic ddc_sda_oe,
   input wire logic mgmt_read,
   input wire logic [31:0] mgmt_readdata
);
   // Raw pin run length; the bench keeps every drop longer than the filter
   logic [15:0] run_q;
   logic [15:0] run_d;
   always_comb begin
      run_d = hpd_in ? run_q + 16'h1 : 16'h0;
   end
   always_ff @(posedge ref_clk) begin
      run_q <= rst ? 16'h0 : run_d;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   AST_HPD_NOT_EARLY: assert property ($rose(hpd_valid) |-> run_q > HPD_QUAL_CYCLES + 2)
      else $error("hot-plug valid too early");
   AST_HPD_ON_TIME: assert property (clk_en && run_q == HPD_QUAL_CYCLES + 10 |-> hpd_valid)
      else $error("hot-plug valid missing");
   AST_HPD_DROP: assert property (!hpd_in [*7] |-> !hpd_valid)
      else $error("hot-plug valid held after drop");
   AST_DDC_RELEASED: assert property ($fell(rst) |-> !ddc_scl_oe && !ddc_sda_oe)
      else $error("DDC line pulled after reset");
   AST_DDC_OPEN_DRAIN: assert property (!ddc_scl_out && !ddc_sda_out)
      else $error("DDC line driven high");
   AST_RD_IDLE_ZERO: assert property (clk_en && !mgmt_read |=> mgmt_readdata == 32'h0)
      else $error("read data without strobe");
   AST_OS_DECODE: assert property (clk_en |=> oversample_factor ==
      ($past(oversample_select) == 2'h0 ? 3'h1 : {1'b0, $past(oversample_select)} + 3'h2))
      else $error("oversampling factor wrong");
endmodule
bind txsb_top txsb_props #(.HPD_QUAL_CYCLES(HPD_QUAL_CYCLES)) txsb_props_inst (.ref_clk, .rst, .clk_en,
   .oversample_select, .oversample_factor, .hpd_in, .hpd_valid, .ddc_scl_out, .ddc_sda_out, .ddc_scl_oe,
   .ddc_sda_oe, .mgmt_read, .mgmt_readdata);
`default_nettype wire

// ==== sim/txsb_sink_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module txsb_sink_model (
   // Master pull-downs
   input wire logic scl_oe,
   input wire logic sda_oe,
   // Lines with pull-ups
   output logic scl,
   output logic sda,
   output logic [7:0] rx_byte
);
   logic [3:0] cnt = 4'h9;
   logic ack = 1'b0;
   assign scl = !scl_oe;
   assign sda = !(sda_oe || ack);
   initial rx_byte = 8'h00;
   // Only a start arms the acknowledge, so a bare read sees released lines
   always @(negedge sda) begin
      if (scl) cnt = 4'h0;
   end
   always @(posedge scl) begin
      if (cnt < 4'h8) rx_byte = {rx_byte[6:0], sda};
      if (cnt < 4'h9) cnt = cnt + 4'h1;
   end
   always @(negedge scl) begin
      ack = (cnt == 4'h8);
   end
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int unsigned QUAL = 20;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic clk_en = 1'b1;
   logic [1:0] sel = 2'h0;
   logic hpd = 1'b0;
   logic [3:0] addr = 4'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [2:0] factor;
   logic valid, scl_oe, sda_oe, scl, sda;
   logic [31:0] rdata;
   logic [7:0] rx_byte;
   int n_mismatch = 0;
   int checked = 0;
   initial forever #25 ref_clk = ~ref_clk;
   txsb_top #(.HPD_QUAL_CYCLES(QUAL)) txsb_top_inst (.ref_clk, .rst, .clk_en, .oversample_select(sel),
      .oversample_factor(factor), .hpd_in(hpd), .hpd_valid(valid), .ddc_scl_in(scl), .ddc_scl_out(),
      .ddc_scl_oe(scl_oe), .ddc_sda_in(sda), .ddc_sda_out(), .ddc_sda_oe(sda_oe), .mgmt_address(addr),
      .mgmt_write(wr), .mgmt_read(rd), .mgmt_writedata(wdata), .mgmt_readdata(rdata));
   txsb_sink_model txsb_sink_model_inst (.scl_oe, .sda_oe, .scl, .sda, .rx_byte);
   task automatic close_out();
      if (n_mismatch == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic cmp(logic [31:0] got, logic [31:0] exp, string msg);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic mm_wr(logic [3:0] a, logic [31:0] d);
      @(negedge ref_clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge ref_clk);
      wr = 1'b0;
   endtask
   task automatic mm_rd(logic [3:0] a, output logic [31:0] d);
      @(negedge ref_clk);
      addr = a;
      rd = 1'b1;
      @(negedge ref_clk);
      rd = 1'b0;
      d = rdata;
   endtask
   task automatic wait_idle(output logic [31:0] st);
      for (int i = 0; i < 2000; i++) begin
         mm_rd(4'h1, st);
         if (st[0] === 1'b0) return;
      end
      n_mismatch++;
      close_out();
   endtask
   task automatic t_os();
      logic [2:0] exp [4] = '{3'h1, 3'h3, 3'h4, 3'h5};
      for (int s = 0; s < 4; s++) begin
         sel = s[1:0];
         tick(1);
         cmp({29'h0, factor}, {29'h0, exp[s]}, "factor");
      end
      // Enable low must freeze the decode as well
      clk_en = 1'b0;
      sel = 2'h0;
      tick(3);
      cmp({29'h0, factor}, 32'h5, "frozen");
      clk_en = 1'b1;
   endtask
   task automatic t_hpd();
      int k = 0;
      hpd = 1'b1;
      tick(QUAL / 2);
      hpd = 1'b0;
      tick(4);
      hpd = 1'b1;
      tick(QUAL);
      cmp({31'h0, valid}, 32'h0, "hpd early");
      while (valid !== 1'b1 && k < 40) begin
         tick(1);
         k++;
      end
      cmp({31'h0, valid}, 32'h1, "hpd missing");
      // Long enough for the on-time property to see its trigger count
      tick(12);
      cmp({31'h0, valid}, 32'h1, "hpd stands");
      hpd = 1'b0;
      tick(7);
      cmp({31'h0, valid}, 32'h0, "hpd held");
   endtask
   task automatic t_ddc();
      logic [31:0] st;
      mm_wr(4'h0, 32'h3A5);
      mm_wr(4'h0, 32'h3FF);
      wait_idle(st);
      cmp({24'h0, rx_byte}, 32'hA5, "wire byte");
      cmp({31'h0, st[1]}, 32'h0, "ack");
      mm_wr(4'h0, 32'hE00);
      wait_idle(st);
      cmp({24'h0, st[15:8]}, 32'hFF, "read byte");
      mm_wr(4'h7, 32'h3A5);
      mm_rd(4'h1, st);
      cmp({31'h0, st[0]}, 32'h0, "stray write");
      mm_rd(4'h5, st);
      cmp(st, 32'h0, "unmapped");
   endtask
   initial begin
      tick(10);
      rst = 1'b0;
      t_os();
      t_hpd();
      t_ddc();
      close_out();
   end
endmodule
`default_nettype wire
